/* rtl/pam_consts.svh */
`ifndef PAM_CONSTS_SVH
`define PAM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PAM_OFS_DIR     8'h00
`define PAM_OFS_LATCH   8'h04
`define PAM_OFS_ANALOG  8'h08
`define PAM_OFS_FUNC    8'h0c
`define PAM_OFS_WDOG    8'h10
`define PAM_OFS_INPUT   8'h14

// ----------------------------------------
// Field positions, widths and pin count
// ----------------------------------------
`define PAM_BG_BIT      4
`define PAM_FUNC_W      2
`define PAM_PIN_CNT     2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PAM_RST_DIR     2'h3
`define PAM_RST_LATCH   2'h0
`define PAM_RST_ANALOG  2'h3
`define PAM_RST_FUNC    4'h0
`define PAM_RST_BG      1'b0

`endif

/* rtl/pam_pin_filter.sv */
`timescale 1ns/1ps
`include "pam_consts.svh"

module pam_pin_filter (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST,
  // Raw pin levels and filtered result
  input  wire logic [`PAM_PIN_CNT-1:0] PIN_RAW,
  output logic      [`PAM_PIN_CNT-1:0] PIN_FILT
);
  import pam_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `PAM_PIN_CNT; i = i + 1)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic filt_q;
      logic agree;
      assign agree = (s2_q == s3_q);
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          s1_q   <= 1'b0;
          s2_q   <= 1'b0;
          s3_q   <= 1'b0;
          filt_q <= 1'b0;
        end
        else
        begin
          s1_q <= PIN_RAW[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (agree)
            filt_q <= s3_q;
        end
      end
      assign PIN_FILT[i] = filt_q;
    end
  endgenerate

endmodule // pam_pin_filter

/* rtl/pam_pkg.sv */
package pam_pkg;

  // Per-pin function selection
  typedef enum logic [1:0] {
    PAM_FN_PORT  = 2'h0,
    PAM_FN_REMAP = 2'h1,
    PAM_FN_PAR   = 2'h2
  } pam_func_e;

  // Digital pad drive for both pins
  typedef struct packed {
    logic [1:0] lvl;
    logic [1:0] oe;
  } pam_pad_s;

  // Parallel master port address lines 6 and 7
  typedef struct packed {
    logic [1:0] lvl;
    logic [1:0] oe;
  } pam_par_s;

endpackage

/* rtl/pam_port_mux.sv */
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "pam_consts.svh"

// Notes on behaviour
// - Input direction routes pin unless analog selected
// - Output direction drives latch, analog irrelevant
// - Reset selects analog input on both pins
// - Remap function follows direction for in/out
// - Parallel port controls pin, direction ignored
// - Bandgap drives second pin while enable set
module pam_port_mux (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // Avalon-MM slave
  input  wire logic [7:0]           ADDRESS,
  input  wire logic                 READ,
  input  wire logic                 WRITE,
  input  wire logic [3:0]           BYTEENABLE,
  input  wire logic [31:0]          WRITEDATA,
  output logic      [31:0]          READDATA,
  output logic                      WAITREQUEST,
  // External pins
  input  wire logic [1:0]           PIN_IN,
  output pam_pkg::pam_pad_s         PAD_OUT,
  output logic                      BANDGAP_OE,
  // Analog side
  output logic      [1:0]           ANALOG_EN,
  // Remappable peripheral side
  input  wire logic [1:0]           REMAP_OUT,
  output logic      [1:0]           REMAP_IN,
  // Parallel master port side
  input  wire pam_pkg::pam_par_s    PAR_DRV,
  output logic      [1:0]           PAR_IN
);
  import pam_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [1:0]  dir_q;
  logic [1:0]  lat_q;
  logic [1:0]  ana_q;
  logic [3:0]  func_q;
  logic        bg_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  filt;
  logic [1:0]  in_val;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire         req      = READ | WRITE;
  wire         wr_acc   = WRITE & ~WAITREQUEST & BYTEENABLE[0];
  wire         hit_dir  = (ADDRESS == `PAM_OFS_DIR);
  wire         hit_lat  = (ADDRESS == `PAM_OFS_LATCH);
  wire         hit_ana  = (ADDRESS == `PAM_OFS_ANALOG);
  wire         hit_func = (ADDRESS == `PAM_OFS_FUNC);
  wire         hit_wdog = (ADDRESS == `PAM_OFS_WDOG);
  wire         hit_in   = (ADDRESS == `PAM_OFS_INPUT);
  wire [7:0]   wdog_rd  = {3'h0, bg_q, 4'h0};
  wire [31:0]  rd_mux   = hit_dir  ? {30'h0, dir_q}  :
                          hit_lat  ? {30'h0, lat_q}  :
                          hit_ana  ? {30'h0, ana_q}  :
                          hit_func ? {28'h0, func_q} :
                          hit_wdog ? {24'h0, wdog_rd} :
                          hit_in   ? {30'h0, in_val} : 32'h0;

  // One wait cycle on every access
  assign WAITREQUEST = req & ~ack_q;
  assign READDATA    = rdata_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (READ & ~ack_q)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      dir_q  <= `PAM_RST_DIR;
      lat_q  <= `PAM_RST_LATCH;
      ana_q  <= `PAM_RST_ANALOG;
      func_q <= `PAM_RST_FUNC;
      bg_q   <= `PAM_RST_BG;
    end
    else
    begin
      if (wr_acc & hit_dir)
        dir_q <= WRITEDATA[1:0];
      if (wr_acc & hit_lat)
        lat_q <= WRITEDATA[1:0];
      if (wr_acc & hit_ana)
        ana_q <= WRITEDATA[1:0];
      if (wr_acc & hit_func)
        func_q <= WRITEDATA[3:0];
      if (wr_acc & hit_wdog)
        bg_q <= WRITEDATA[`PAM_BG_BIT];
    end
  end

  // ----------------------------------------
  // Pin input conditioning
  // ----------------------------------------
  pam_pin_filter u_filter (
    .CLK      (CLK),
    .RST      (RST),
    .PIN_RAW  (PIN_IN),
    .PIN_FILT (filt)
  );

  // ----------------------------------------
  // Per-pin function routing
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `PAM_PIN_CNT; i = i + 1)
    begin : g_pin
      wire [1:0] fsel   = func_q[`PAM_FUNC_W*i +: `PAM_FUNC_W];
      wire       is_rm  = (fsel == PAM_FN_REMAP);
      wire       is_par = (fsel == PAM_FN_PAR);
      wire       dig_en = ~ana_q[i];
      wire       bg_blk = (i == 1) && bg_q;
      wire       lvl_d  = is_par ? PAR_DRV.lvl[i] :
                          is_rm  ? REMAP_OUT[i]   : lat_q[i];
      wire       oe_d   = is_par ? PAR_DRV.oe[i]  : ~dir_q[i];
      // Digital input buffer off while analog selected
      assign in_val[i]      = filt[i] & dig_en;
      assign REMAP_IN[i]    = is_rm & dir_q[i] & filt[i] & dig_en;
      assign PAR_IN[i]      = is_par & filt[i] & dig_en;
      assign PAD_OUT.lvl[i] = lvl_d;
      assign PAD_OUT.oe[i]  = oe_d & ~bg_blk;
    end
  endgenerate

  assign ANALOG_EN  = ana_q;
  assign BANDGAP_OE = bg_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  wire p0_port = (func_q[1:0] == PAM_FN_PORT);
  wire p1_rm   = (func_q[3:2] == PAM_FN_REMAP);
  wire p1_port = (func_q[3:2] == PAM_FN_PORT);

  chk_din_route: assert property (
    (p0_port && dir_q[0] && !ana_q[0] && $stable(PIN_IN[0]))[*5]
    |-> in_val[0] == PIN_IN[0])
    else $error("pin0 input not routed to input value");

  chk_dout_latch: assert property (
    (p0_port && !dir_q[0])
    |-> PAD_OUT.oe[0] && PAD_OUT.lvl[0] == lat_q[0])
    else $error("pin0 not driven from latch");

  chk_reset_analog: assert property (
    $past(RST) |-> ana_q == `PAM_RST_ANALOG && ANALOG_EN == `PAM_RST_ANALOG)
    else $error("analog not selected after reset");

  chk_remap_path: assert property (
    (p1_rm && !dir_q[1] && !bg_q)
    |-> PAD_OUT.oe[1] && PAD_OUT.lvl[1] == REMAP_OUT[1])
    else $error("pin1 not driven from remap output");

  chk_par_ctrl: assert property (
    (func_q[1:0] == PAM_FN_PAR)
    |-> PAD_OUT.oe[0] == PAR_DRV.oe[0] && PAD_OUT.lvl[0] == PAR_DRV.lvl[0])
    else $error("parallel port lost control of pin0");

  chk_bg_enable: assert property (
    (wr_acc && hit_wdog)
    |=> BANDGAP_OE == $past(WRITEDATA[`PAM_BG_BIT]) && (!BANDGAP_OE || !PAD_OUT.oe[1]))
    else $error("bandgap drive does not follow enable");

  chk_ana_zero: assert property (
    (ana_q[1] && READ && !WAITREQUEST && hit_in) |-> READDATA[1] == 1'b0)
    else $error("analog pin read nonzero");

  chk_bus_wait: assert property (
    (req && !ack_q) |-> WAITREQUEST ##1 (!WAITREQUEST || !req))
    else $error("access not answered after one wait cycle");

  chk_pin1_latch: assert property (
    (p1_port && !dir_q[1] && !bg_q)
    |-> PAD_OUT.oe[1] && PAD_OUT.lvl[1] == lat_q[1])
    else $error("pin1 not driven from latch");

  chk_rm_input: assert property (
    (dir_q == 2'h0) |-> REMAP_IN == 2'h0)
    else $error("remap input fed while pins drive");

  chk_ana_gate: assert property (
    (ana_q == 2'h3) |-> in_val == 2'h0 && REMAP_IN == 2'h0 && PAR_IN == 2'h0)
    else $error("analog pins leak digital input");

  chk_bg_pin0: assert property (
    (bg_q && p0_port && !dir_q[0])
    |-> PAD_OUT.oe[0] && PAD_OUT.lvl[0] == lat_q[0])
    else $error("bandgap disturbed pin0 drive");

  chk_bg_block: assert property (
    BANDGAP_OE |-> !PAD_OUT.oe[1])
    else $error("pin1 driven while bandgap enabled");

  chk_be_ignored: assert property (
    (WRITE && !WAITREQUEST && !BYTEENABLE[0])
    |=> $stable(dir_q) && $stable(lat_q) && $stable(ana_q)
        && $stable(func_q) && $stable(bg_q))
    else $error("write without byte enable changed a register");

endmodule // pam_port_mux

/* verif/pam_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Pin level as seen from outside
// ----------------------------------------
module pam_far_model (
  // Digital pad drive from the block
  input  pam_pkg::pam_pad_s pad,
  // Level applied by the outside world
  input  logic [1:0]        ext_lvl,
  // Resolved pin level
  output logic [1:0]        pin
);
  import pam_pkg::*;
  // Driven pad wins over the outside level
  assign pin = (pad.oe & pad.lvl) | (~pad.oe & ext_lvl);
endmodule // pam_far_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import pam_pkg::*;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, bg, wq;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  be = 4'h1;
  logic [31:0] wd = 32'h0, q, rdata;
  logic [1:0]  ext = 2'h0, rmo = 2'h0, pin, an, rmi, pin_par;
  pam_par_s    par = '0;
  pam_pad_s    pad;
  int          bad_count = 0, n_checks = 0;

  pam_port_mux uut (.CLK(clk), .RST(rst), .ADDRESS(adr), .READ(rd), .WRITE(wr),
    .BYTEENABLE(be), .WRITEDATA(wd), .READDATA(q), .WAITREQUEST(wq), .PIN_IN(pin),
    .PAD_OUT(pad), .BANDGAP_OE(bg), .ANALOG_EN(an), .REMAP_OUT(rmo), .REMAP_IN(rmi),
    .PAR_DRV(par), .PAR_IN(pin_par));
  pam_far_model far (.pad(pad), .ext_lvl(ext), .pin(pin));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    rdata = q;
    rd <= 1'b0; wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pins(input logic [1:0] v);
    ext <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset;
    bus(0, 8'h00, 0); chk(rdata, 32'h3);
    bus(0, 8'h08, 0); chk(rdata, 32'h3);
    pins(2'h3);
    bus(0, 8'h14, 0); chk(rdata, 32'h0);
    chk({an, pad.oe, bg}, 32'h18);
  endtask

  task automatic t_in;
    bus(1, 8'h08, 0); bus(1, 8'h04, 2); pins(2'h1);
    bus(0, 8'h14, 0); chk(rdata, 32'h1);
    chk(pad.oe, 32'h0);
    bus(0, 8'h40, 0); chk(rdata, 32'h0);
  endtask

  task automatic t_out;
    bus(1, 8'h00, 0); chk({pad.oe, pad.lvl}, 32'he);
    bus(1, 8'h08, 3); chk({pad.oe, pad.lvl}, 32'he);
    bus(0, 8'h14, 0); chk(rdata, 32'h0);
  endtask

  task automatic t_remap;
    bus(1, 8'h08, 0); bus(1, 8'h0c, 5); bus(1, 8'h00, 3); pins(2'h2);
    chk(rmi, 32'h2);
    rmo <= 2'h1;
    bus(1, 8'h00, 0); chk({pad.oe, pad.lvl, rmi}, 32'h34);
  endtask

  task automatic t_par;
    par <= '{lvl: 2'h2, oe: 2'h3};
    bus(1, 8'h0c, 32'ha); chk({pad.oe, pad.lvl}, 32'he);
    par <= '{lvl: 2'h0, oe: 2'h0}; pins(2'h1);
    chk({pad.oe, pin_par}, 32'h1);
  endtask

  task automatic t_bg;
    bus(1, 8'h0c, 0); bus(1, 8'h10, 32'h10);
    chk({bg, pad.oe}, 32'h5);
    bus(0, 8'h10, 0); chk(rdata, 32'h10);
    bus(1, 8'h10, 0); chk({bg, pad.oe}, 32'h3);
  endtask

  task automatic t_misc;
    bus(1, 8'h0c, 32'hf); chk({pad.oe, pad.lvl}, 32'he);
    be <= 4'h0;
    bus(1, 8'h04, 32'h1); chk({pad.oe, pad.lvl}, 32'he);
    bus(0, 8'h04, 0); chk(rdata, 32'h2);
    be <= 4'h1;
    bus(1, 8'h08, 32'h1); chk({an, pad.oe, pad.lvl}, 32'h1e);
  endtask

  task automatic t_rst2;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'h08, 0); chk(rdata, 32'h3);
    chk({an, pad.oe, bg}, 32'h18);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset; t_in; t_out; t_remap; t_par; t_bg; t_misc; t_rst2;
    print_verdict;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
endmodule // tb
